/* hw/hbm_defines.vh */
// hbm_defines.vh: offsets, field positions, reset values and timing figures
// for the half-bridge mode and dead/blank timing register bank.
// assumes a 40 MHz core clock; included by bare name.
`ifndef HBM_DEFINES_VH
`define HBM_DEFINES_VH

// ************************************************************
// register map
// ************************************************************
`define HBM_OFS_TIMING 5'h05
`define HBM_OFS_MODE 5'h06
`define HBM_BANK_FW 1'h1
`define HBM_BANK_ACT 1'h0
`define HBM_RST_TIMING 15'h4924
`define HBM_RST_MODE 16'h0000

// ************************************************************
// timing register fields
// ************************************************************
`define HBM_DEAD1_LSB 0
`define HBM_BLANK1_LSB 3
`define HBM_DEAD2_LSB 6
`define HBM_BLANK2_LSB 9
`define HBM_DEAD3_LSB 12
`define HBM_FIELD_W 3
`define HBM_MODE_W 2

// ************************************************************
// bridge mode codes
// ************************************************************
`define HBM_MODE_LOW 2'h1
`define HBM_MODE_HIGH 2'h2

// ************************************************************
// timing figures (ns) and cycle conversion
// ************************************************************
`define HBM_CLK_MHZ 40
`define HBM_CYC(ns) (((ns) * `HBM_CLK_MHZ + 999) / 1000)
`define HBM_DEAD_NS0 375
`define HBM_DEAD_NS1 625
`define HBM_DEAD_NS2 1000
`define HBM_DEAD_NS3 1500
`define HBM_DEAD_NS4 2000
`define HBM_DEAD_NS5 3000
`define HBM_DEAD_NS6 4000
`define HBM_DEAD_NS7 16000
`define HBM_BLANK_NS0 625
`define HBM_BLANK_NS1 1000
`define HBM_BLANK_NS2 1250
`define HBM_BLANK_NS3 1500
`define HBM_BLANK_NS4 2000
`define HBM_BLANK_NS5 3000
`define HBM_BLANK_NS6 4000
`define HBM_BLANK_NS7 16000
`define HBM_CNT_W 10

`endif

/* hw/hbm_bridge_ctrl.v */
// hbm_bridge_ctrl.v: one half-bridge gate sequencer with dead time and
// drain-source blanking.
// assumes synchronised fault inputs and codes held stable by the register bank.
`timescale 1ns/10ps
`default_nettype none
`include "hbm_defines.vh"

module hbm_bridge_ctrl (
  input wire clock,
  input wire rst_n,
  input wire [1:0] modeCode,
  input wire activeIsHigh,
  input wire [2:0] fwDead,
  input wire [2:0] fwBlank,
  input wire [2:0] actDead,
  input wire [2:0] actBlank,
  input wire dsOvHigh,
  input wire dsOvLow,
  output reg gateHigh,
  output reg gateLow,
  output reg dsFault
);

  localparam S_OFF = 2'd0;
  localparam S_DEAD = 2'd1;
  localparam S_LOW = 2'd2;
  localparam S_HIGH = 2'd3;

  // ************************************************************
  // code to cycle conversion
  // ************************************************************
  // cycle counts are worked out at full integer width and cut to the counter on purpose
  function [`HBM_CNT_W-1:0] deadCycles;
    input [2:0] code;
    reg [31:0] cyc;
    begin
      case (code)
        3'h0: cyc = `HBM_CYC(`HBM_DEAD_NS0);
        3'h1: cyc = `HBM_CYC(`HBM_DEAD_NS1);
        3'h2: cyc = `HBM_CYC(`HBM_DEAD_NS2);
        3'h3: cyc = `HBM_CYC(`HBM_DEAD_NS3);
        3'h4: cyc = `HBM_CYC(`HBM_DEAD_NS4);
        3'h5: cyc = `HBM_CYC(`HBM_DEAD_NS5);
        3'h6: cyc = `HBM_CYC(`HBM_DEAD_NS6);
        default: cyc = `HBM_CYC(`HBM_DEAD_NS7);
      endcase
      deadCycles = cyc[`HBM_CNT_W-1:0];
    end
  endfunction

  function [`HBM_CNT_W-1:0] blankCycles;
    input [2:0] code;
    reg [31:0] cyc;
    begin
      case (code)
        3'h0: cyc = `HBM_CYC(`HBM_BLANK_NS0);
        3'h1: cyc = `HBM_CYC(`HBM_BLANK_NS1);
        3'h2: cyc = `HBM_CYC(`HBM_BLANK_NS2);
        3'h3: cyc = `HBM_CYC(`HBM_BLANK_NS3);
        3'h4: cyc = `HBM_CYC(`HBM_BLANK_NS4);
        3'h5: cyc = `HBM_CYC(`HBM_BLANK_NS5);
        3'h6: cyc = `HBM_CYC(`HBM_BLANK_NS6);
        default: cyc = `HBM_CYC(`HBM_BLANK_NS7);
      endcase
      blankCycles = cyc[`HBM_CNT_W-1:0];
    end
  endfunction

  // ************************************************************
  // sequencer
  // ************************************************************
  reg [1:0] state_q;
  reg [`HBM_CNT_W-1:0] dead_q;
  reg [`HBM_CNT_W-1:0] blank_q;
  reg wasOn_q;
  reg lastHigh_q;
  wire wantHigh = (modeCode == `HBM_MODE_HIGH);
  wire wantLow = (modeCode == `HBM_MODE_LOW);
  // freewheel times go to the non-switching side only
  wire [2:0] hiDead = activeIsHigh ? actDead : fwDead;
  wire [2:0] hiBlank = activeIsHigh ? actBlank : fwBlank;
  wire [2:0] loDead = activeIsHigh ? fwDead : actDead;
  wire [2:0] loBlank = activeIsHigh ? fwBlank : actBlank;
  wire [`HBM_CNT_W-1:0] newDead = deadCycles(wantHigh ? hiDead : loDead);
  wire [`HBM_CNT_W-1:0] newBlank = blankCycles(wantHigh ? hiBlank : loBlank);
  wire sideChange = wasOn_q && (lastHigh_q != wantHigh);

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_OFF;
      dead_q <= {`HBM_CNT_W{1'b0}};
      blank_q <= {`HBM_CNT_W{1'b0}};
      wasOn_q <= 1'b0;
      lastHigh_q <= 1'b0;
      gateHigh <= 1'b0;
      gateLow <= 1'b0;
      dsFault <= 1'b0;
    end
    else
    begin
      if (blank_q != {`HBM_CNT_W{1'b0}})
        blank_q <= blank_q - 1'b1;
      case (state_q)
        S_OFF:
        begin
          if (wantHigh || wantLow)
          begin
            if (sideChange)
            begin
              // hold both gates off before the opposite side conducts
              state_q <= S_DEAD;
              dead_q <= newDead - 1'b1;
            end
            else
            begin
              state_q <= wantHigh ? S_HIGH : S_LOW;
              blank_q <= newBlank;
            end
          end
        end
        S_DEAD:
        begin
          if (!(wantHigh || wantLow))
            state_q <= S_OFF;
          else if (dead_q == {`HBM_CNT_W{1'b0}})
          begin
            state_q <= wantHigh ? S_HIGH : S_LOW;
            blank_q <= newBlank;
          end
          else
            dead_q <= dead_q - 1'b1;
        end
        S_LOW, S_HIGH:
        begin
          if (!(wantHigh || wantLow))
            state_q <= S_OFF;
          else if (wantHigh != (state_q == S_HIGH))
          begin
            state_q <= S_DEAD;
            dead_q <= newDead - 1'b1;
          end
        end
        default: state_q <= S_OFF;
      endcase
      if (state_q == S_HIGH || state_q == S_LOW)
      begin
        wasOn_q <= 1'b1;
        lastHigh_q <= (state_q == S_HIGH);
      end
      gateHigh <= (state_q == S_HIGH);
      gateLow <= (state_q == S_LOW);
      // fault is masked while the blank counter runs
      dsFault <= (blank_q == {`HBM_CNT_W{1'b0}}) &&
        (((state_q == S_HIGH) && dsOvHigh) || ((state_q == S_LOW) && dsOvLow));
    end
  end

endmodule // hbm_bridge_ctrl

`default_nettype wire

/* hw/hbm_regs.v */
// hbm_regs.v: half-bridge mode and dead/blank timing register bank with
// eight bridge sequencers.
// assumes a serial frame decoder on the same clock driving the register port,
// and the set-mapping and set-3/4 registers held elsewhere.
`timescale 1ns/10ps
`default_nettype none
`include "hbm_defines.vh"

module hbm_regs (
  input wire clock,
  input wire rst_n,
  input wire regWrEn,
  input wire regRdEn,
  input wire regBank,
  input wire [4:0] regAddr,
  input wire [15:0] regWrData,
  output reg [15:0] regRdData,
  input wire [15:0] timingSetMap,
  input wire [2:0] fwBlank3,
  input wire [2:0] fwDead4,
  input wire [2:0] fwBlank4,
  input wire [2:0] actBlank3,
  input wire [2:0] actDead4,
  input wire [2:0] actBlank4,
  input wire [7:0] activeIsHigh,
  input wire [7:0] dsOvHighPin,
  input wire [7:0] dsOvLowPin,
  output wire [7:0] gateHigh,
  output wire [7:0] gateLow,
  output wire [7:0] dsFault
);

  // ************************************************************
  // registers
  // ************************************************************
  reg [14:0] fwTiming_q;
  reg [14:0] actTiming_q;
  reg [15:0] mode_q;
  wire hitTiming = (regAddr == `HBM_OFS_TIMING);
  wire hitMode = (regAddr == `HBM_OFS_MODE);

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fwTiming_q <= `HBM_RST_TIMING;
      actTiming_q <= `HBM_RST_TIMING;
      mode_q <= `HBM_RST_MODE;
      regRdData <= 16'h0000;
    end
    else
    begin
      if (regWrEn && hitTiming && regBank == `HBM_BANK_FW)
        fwTiming_q <= regWrData[14:0];
      if (regWrEn && hitTiming && regBank == `HBM_BANK_ACT)
        actTiming_q <= regWrData[14:0];
      if (regWrEn && hitMode)
        mode_q <= regWrData;
      if (regRdEn)
      begin
        if (hitTiming)
          regRdData <= {1'b0, (regBank == `HBM_BANK_FW) ? fwTiming_q : actTiming_q};
        else if (hitMode)
          regRdData <= mode_q;
        else
          regRdData <= 16'h0000;
      end
    end
  end

  // ************************************************************
  // fault input synchroniser
  // ************************************************************
  reg [15:0] dsMeta_q;
  reg [15:0] dsSync_q;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dsMeta_q <= 16'h0000;
      dsSync_q <= 16'h0000;
    end
    else
    begin
      dsMeta_q <= {dsOvHighPin, dsOvLowPin};
      dsSync_q <= dsMeta_q;
    end
  end

  // ************************************************************
  // timing set selection
  // ************************************************************
  // set 3 is partly and set 4 wholly held in another register, hence the inputs
  function [2:0] pickDead;
    input [1:0] sel;
    input [14:0] regv;
    input [2:0] dead4;
    begin
      case (sel)
        2'h0: pickDead = regv[`HBM_DEAD1_LSB +: `HBM_FIELD_W];
        2'h1: pickDead = regv[`HBM_DEAD2_LSB +: `HBM_FIELD_W];
        2'h2: pickDead = regv[`HBM_DEAD3_LSB +: `HBM_FIELD_W];
        default: pickDead = dead4;
      endcase
    end
  endfunction

  function [2:0] pickBlank;
    input [1:0] sel;
    input [14:0] regv;
    input [2:0] blank3;
    input [2:0] blank4;
    begin
      case (sel)
        2'h0: pickBlank = regv[`HBM_BLANK1_LSB +: `HBM_FIELD_W];
        2'h1: pickBlank = regv[`HBM_BLANK2_LSB +: `HBM_FIELD_W];
        2'h2: pickBlank = blank3;
        default: pickBlank = blank4;
      endcase
    end
  endfunction

  // ************************************************************
  // bridge sequencers
  // ************************************************************
  genvar n;
  generate
    for (n = 0; n < 8; n = n + 1)
    begin : gBridge
      wire [1:0] setSel = timingSetMap[2*n +: 2];
      hbm_bridge_ctrl uBridge (
        .clock(clock),
        .rst_n(rst_n),
        .modeCode(mode_q[`HBM_MODE_W*n +: `HBM_MODE_W]),
        .activeIsHigh(activeIsHigh[n]),
        .fwDead(pickDead(setSel, fwTiming_q, fwDead4)),
        .fwBlank(pickBlank(setSel, fwTiming_q, fwBlank3, fwBlank4)),
        .actDead(pickDead(setSel, actTiming_q, actDead4)),
        .actBlank(pickBlank(setSel, actTiming_q, actBlank3, actBlank4)),
        .dsOvHigh(dsSync_q[8+n]),
        .dsOvLow(dsSync_q[n]),
        .gateHigh(gateHigh[n]),
        .gateLow(gateLow[n]),
        .dsFault(dsFault[n])
      );
    end
  endgenerate

endmodule // hbm_regs

`default_nettype wire

/* bench/hbm_regs_props.sv */
// hbm_regs_props.sv: port checks of the mode and timing register bank.
// assumes bridge 1 mode writes come one at a time, two cycles apart.
`timescale 1ns/10ps
`default_nettype none
module hbm_regs_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic [7:0] gateHigh,
  input wire logic [7:0] gateLow,
  input wire logic [7:0] dsFault
);
  // ***
  // properties
  // ***
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence sModeWr(logic [1:0] c);
    regWrEn && regAddr == 5'h06 && regWrData[1:0] == c;
  endsequence
  sequence sModeRd;
    regRdEn && regAddr == 5'h06;
  endsequence
  a_bit15_zero: assert property ($past(regRdEn) && $past(regAddr) == 5'h05 |-> !regRdData[15])
    else $error("timing bit 15 read as one");
  a_unmapped_zero: assert property (regRdEn && regAddr != 5'h05 && regAddr != 5'h06 |=> regRdData == 16'h0000)
    else $error("unmapped read not zero");
  a_mode_readback: assert property (regWrEn && regAddr == 5'h06 ##2 sModeRd |=> regRdData == $past(regWrData, 3))
    else $error("mode read differs from write");
  a_no_shoot: assert property ((gateHigh & gateLow) == 8'h00)
    else $error("both gates of a bridge on");
  a_dead_gap: assert property ($fell(gateLow[0]) |-> !gateHigh[0] [*8])
    else $error("high gate on inside dead time");
  a_mode_off: assert property (regWrEn && regAddr == 5'h06 && (regWrData[1:0] == 2'h0 || regWrData[1:0] == 2'h3) |-> ##3 !gateHigh[0] && !gateLow[0])
    else $error("bridge not off after off code");
  a_low_on: assert property (sModeWr(2'h1) |-> ##3 !gateHigh[0] ##[0:700] gateLow[0])
    else $error("low side did not come on");
  a_high_on: assert property (sModeWr(2'h2) |-> ##3 !gateLow[0] ##[0:700] gateHigh[0])
    else $error("high side did not come on");
  a_fault_masked: assert property ($rose(gateLow[0]) |-> !dsFault[0] [*8])
    else $error("fault shown inside blanking");
endmodule // hbm_regs_props
bind hbm_regs hbm_regs_props u_props (.clock(clock), .rst_n(rst_n), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
  .gateHigh(gateHigh), .gateLow(gateLow), .dsFault(dsFault));
`default_nettype wire

/* bench/hbm_host_model.sv */
// hbm_host_model.sv: host side of the register port, one access per call.
// assumes a shared clock; requests move 1 ns after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module hbm_host_model (
  input wire logic clock,
  output logic regWrEn,
  output logic regRdEn,
  output logic regBank,
  output logic [4:0] regAddr,
  output logic [15:0] regWrData
);
  // ***
  // register access
  // ***
  initial
  begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regBank = 1'b0;
    regAddr = 5'h00;
    regWrData = 16'h0000;
  end
  task acc(input logic w, input logic b, input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    regWrEn = w; // no gate current setting is sent
    regRdEn = ~w;
    regBank = b;
    regAddr = a;
    regWrData = d;
    @(posedge clock);
    #1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    // idle lines wander so a stale value never passes for a request
    regAddr = ~a;
    regWrData = ~d;
  endtask
endmodule // hbm_host_model
`default_nettype wire

/* bench/hbm_regs_test.sv */
// hbm_regs_test.sv: self-checking bench for the mode and timing bank.
// assumes the host model drives the register port and the checker is bound.
`timescale 1ns/10ps
`default_nettype none
`include "hbm_defines.vh"
module hbm_regs_test;
  logic clock, rst_n, regWrEn, regRdEn, regBank;
  logic [4:0] regAddr;
  logic [15:0] regWrData, regRdData, timingSetMap, modeVal;
  logic [2:0] fwBlank3, fwDead4, fwBlank4, actBlank3, actDead4, actBlank4;
  logic [7:0] activeIsHigh, dsOvHighPin, dsOvLowPin, gateHigh, gateLow, dsFault;
  logic [2:0] watched;
  logic [15:0] rdQ[$];
  int deadQ[$];
  int deadCyc[8] = '{15, 25, 40, 60, 80, 120, 160, 640};
  int mismatches = 0, n_checks = 0, offCnt = 0, k;
  logic rdSeen = 1'b0, lowPrev = 1'b0;
  assign watched = {dsFault[0], gateLow[0], gateHigh[0]};
  hbm_host_model u_host (.clock(clock), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regBank(regBank), .regAddr(regAddr), .regWrData(regWrData));
  hbm_regs u_dut (.clock(clock), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regBank(regBank), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .timingSetMap(timingSetMap), .fwBlank3(fwBlank3), .fwDead4(fwDead4), .fwBlank4(fwBlank4),
    .actBlank3(actBlank3), .actDead4(actDead4), .actBlank4(actBlank4),
    .activeIsHigh(activeIsHigh), .dsOvHighPin(dsOvHighPin), .dsOvLowPin(dsOvLowPin),
    .gateHigh(gateHigh), .gateLow(gateLow), .dsFault(dsFault));
  // ***
  // clock, compares and report
  // ***
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task cmpWord(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmpCount(input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task rd(input logic b, input logic [4:0] a, input logic [15:0] exp);
    rdQ.push_back(exp);
    u_host.acc(1'b0, b, a, 16'h0000);
  endtask
  task wr(input logic b, input logic [4:0] a, input logic [15:0] d);
    u_host.acc(1'b1, b, a, d);
  endtask
  // bounded wait on gate high, gate low or fault of bridge 1
  task waitBit(input int sel);
    k = 0;
    while (k < 800 && watched[sel] !== 1'b1)
    begin
      @(posedge clock);
      k++;
    end
    #1;
    if (k == 800)
    begin
      mismatches++;
      tally_and_finish;
    end
  endtask
  // read data lands one edge after the read; dead time counts all-off samples
  always @(posedge clock)
  begin
    if (rdSeen && rdQ.size() > 0)
      cmpWord(regRdData, rdQ.pop_front());
    if (gateLow[0] === 1'b1 && lowPrev === 1'b0 && deadQ.size() > 0)
      cmpCount(offCnt, deadQ.pop_front());
    offCnt = (gateLow[0] | gateHigh[0]) ? 0 : offCnt + 1;
    lowPrev = gateLow[0];
    rdSeen = regRdEn;
  end
  // ***
  // main sequence
  // ***
  initial
  begin
    void'($urandom(43481));
    rst_n = 1'b0;
    timingSetMap = 16'($urandom()) & 16'hFFFC;
    {fwBlank3, fwDead4, fwBlank4} = 9'($urandom());
    {actBlank3, actDead4, actBlank4} = 9'($urandom());
    activeIsHigh = 8'($urandom()) | 8'h01;
    dsOvHighPin = 8'($urandom()) & 8'hFE;
    dsOvLowPin = 8'h00;
    repeat (10) @(posedge clock);
    #1 rst_n = 1'b1;
    rd(1'b1, 5'h05, {1'b0, `HBM_RST_TIMING});
    rd(1'b0, 5'h05, {1'b0, `HBM_RST_TIMING});
    rd(1'b0, 5'h06, `HBM_RST_MODE);
    wr(1'b1, 5'h05, 16'hFFFF);
    rd(1'b1, 5'h05, 16'h7FFF);
    rd(1'b0, 5'h05, {1'b0, `HBM_RST_TIMING});
    rd(1'b1, 5'h07, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      modeVal = 16'($urandom()) & 16'hFFFC;
      wr(i[0], 5'h06, modeVal);
      rd(~i[0], 5'h06, modeVal);
    end
    // low side is freewheeling on bridge 1, so its dead time is fw set 1
    for (int c = 0; c < 8; c++)
    begin
      wr(1'b1, 5'h05, 16'h4920 | 16'(c));
      wr(1'b0, 5'h06, 16'h0002);
      waitBit(0);
      deadQ.push_back(deadCyc[c]);
      if (c == 7)
        dsOvLowPin = 8'hFF;
      wr(1'b0, 5'h06, 16'h0001);
      waitBit(1);
    end
    repeat (20) @(posedge clock);
    #1;
    cmpWord({15'h0000, dsFault[0]}, 16'h0000);
    waitBit(2);
    cmpWord({15'h0000, dsFault[0]}, 16'h0001);
    wr(1'b1, 5'h06, 16'h0003);
    repeat (3) @(posedge clock);
    #1;
    cmpWord({14'h0000, gateHigh[0], gateLow[0]}, 16'h0000);
    tally_and_finish;
  end
endmodule // hbm_regs_test
`default_nettype wire
